// ---- hdl/cfg_header_regs.vh ----
`ifndef CFG_HEADER_REGS_VH
`define CFG_HEADER_REGS_VH

// configuration space byte offsets
`define CFG_VENDOR_IDENTIFIER_OFS 8'h00
`define CFG_DEVICE_IDENTIFIER_OFS 8'h02
`define CFG_COMMAND_CONTROL_OFS   8'h04
`define CFG_MMIO_BASE_OFS         8'h10

// the only function this device claims
`define CFG_OWN_FUNCTION          3'h0

// command_control field positions
`define CMD_IO_ENABLE_BIT         0
`define CMD_MEM_ENABLE_BIT        1
`define CMD_MASTER_ENABLE_BIT     2
`define CMD_RESET                 16'h0000
`define CMD_WRITE_MASK            16'h0006

// memory window: 2048 bytes, base held in bits 31..11
`define MMIO_WINDOW_BITS          11
`define MMIO_BASE_RESET           21'h000000

`endif

// ---- hdl/mmio_window_decode.v ----
`timescale 1ns/10ps
module mmio_window_decode #(
    parameter ADDR_WIDTH   = 32,
    parameter WINDOW_BITS  = 11
) (
    input  wire                          access_valid_in,
    input  wire [ADDR_WIDTH-1:0]         access_addr_in,
    input  wire [ADDR_WIDTH-WINDOW_BITS-1:0] window_base_in,
    input  wire                          decode_enable_in,
    output wire                          window_hit_out,
    output wire [WINDOW_BITS-1:0]        window_offset_out
);
    // upper bits must match the programmed base; low bits are the offset
    wire base_match;

    assign base_match        = (access_addr_in[ADDR_WIDTH-1:WINDOW_BITS] == window_base_in);
    assign window_hit_out    = access_valid_in & decode_enable_in & base_match; // [RULE2] [RULE7]
    assign window_offset_out = access_addr_in[WINDOW_BITS-1:0]; // [RULE2]
endmodule

// ---- hdl/pci_config_command_header.v ----
// Function
// RULE1: configuration registers answer only cycles addressed to function zero; cfg_ack_out is still given for every function.
// RULE2: controller registers decode in memory space as offsets from the base register.
// RULE3: fixed read-only device identifier at bytes 3..2; writes ignored.
// RULE4: fast back-to-back, postable write, special cycle bits read zero, writes ignored.
// RULE5: error reporting and parity response bits read zero and stay disabled.
// RULE6: wait cycle control and palette snoop bits read constant zero.
// RULE7: memory enable resets to zero; while zero memory accesses are not claimed.
// RULE8: bus master enable is writable, resets zero; no mastering while clear.
`timescale 1ns/10ps
`include "cfg_header_regs.vh"
module pci_config_command_header #(
    parameter [15:0] VENDOR_CODE = 16'h1234, // value is arbitrary
    parameter [15:0] DEVICE_CODE = 16'h5678  // value is arbitrary
) (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire        cfg_valid_in,
    input  wire        cfg_write_in,
    input  wire [2:0]  cfg_function_in,
    input  wire [7:0]  cfg_offset_in,
    input  wire [3:0]  cfg_byte_en_in,
    input  wire [31:0] cfg_wdata_in,
    output reg         cfg_ack_out,
    output reg         cfg_claim_out,
    output reg  [31:0] cfg_rdata_out,
    input  wire        mem_valid_in,
    input  wire [31:0] mem_addr_in,
    output reg         mem_hit_out,
    output reg  [10:0] mem_offset_out,
    input  wire        master_req_in,
    output reg         master_req_out,
    output reg         mem_enable_out,
    output reg         master_enable_out
);
    // dword selects come from the byte offsets; offset bits 1..0 are ignored
    localparam        BASE_W    = 32 - `MMIO_WINDOW_BITS;
    localparam        WIN_W     = `MMIO_WINDOW_BITS;
    localparam [7:0]  ID_OFS    = `CFG_VENDOR_IDENTIFIER_OFS;
    localparam [7:0]  CMD_OFS   = `CFG_COMMAND_CONTROL_OFS;
    localparam [7:0]  BASE_OFS  = `CFG_MMIO_BASE_OFS;
    localparam [15:0] CMD_WMASK = `CMD_WRITE_MASK;

    reg  [15:0]       command_control;
    reg  [BASE_W-1:0] mmio_base;
    reg  [31:0]       next_rdata;
    wire              own_function;
    wire [5:0]        dword_index;
    wire              cfg_read_hit;
    wire              cfg_write_hit;
    wire              cmd_write_strobe;
    wire              base_write_strobe;
    wire [15:0]       command_write;
    wire [15:0]       next_command;
    wire [BASE_W-1:0] base_lane_en;
    wire [BASE_W-1:0] next_base;
    wire              window_hit;
    wire [WIN_W-1:0]  window_offset;
    wire              mem_enable;
    wire              master_enable;
    wire [31:0]       id_dword;
    wire [31:0]       cmd_dword;
    wire [31:0]       base_dword;
    genvar            n;
    genvar            k;

    assign own_function      = (cfg_function_in == `CFG_OWN_FUNCTION); // [RULE1]
    assign dword_index       = cfg_offset_in[7:2];
    assign cfg_read_hit      = cfg_valid_in & ~cfg_write_in & own_function; // [RULE1]
    assign cfg_write_hit     = cfg_valid_in & cfg_write_in & own_function; // [RULE1]
    // identifier dword has no storage, so a write there simply vanishes
    assign cmd_write_strobe  = cfg_write_hit & (dword_index == CMD_OFS[7:2]); // [RULE3]
    assign base_write_strobe = cfg_write_hit & (dword_index == BASE_OFS[7:2]); // [RULE2]
    assign next_command      = cmd_write_strobe ? command_write : command_control;
    assign mem_enable        = command_control[`CMD_MEM_ENABLE_BIT]; // [RULE7]
    assign master_enable     = command_control[`CMD_MASTER_ENABLE_BIT]; // [RULE8]

    // only the memory and master enable bits can ever hold a one; the rest, I/O enable included, is hard-wired zero
    generate
        for (n = 0; n < 16; n = n + 1) begin : g_cmd_bit
            if (CMD_WMASK[n]) begin : g_writable
                assign command_write[n] = cfg_wdata_in[n] & cfg_byte_en_in[n / 8]; // [RULE7] [RULE8]
            end else begin : g_fixed
                assign command_write[n] = 1'b0; // [RULE4] [RULE5] [RULE6]
            end
        end
    endgenerate

    // base bits follow their byte lane; bits below the window never store
    generate
        for (k = 0; k < BASE_W; k = k + 1) begin : g_base_bit
            assign base_lane_en[k] = cfg_byte_en_in[(k + WIN_W) / 8];
            assign next_base[k]    = (base_write_strobe && base_lane_en[k]) ?
                                     cfg_wdata_in[k + WIN_W] : mmio_base[k];
        end
    endgenerate

    assign id_dword   = {DEVICE_CODE, VENDOR_CODE}; // [RULE3]
    // status half lies outside this block and reads zero here
    assign cmd_dword  = {16'h0000, command_control}; // [RULE4] [RULE5] [RULE6]
    assign base_dword = {mmio_base, {WIN_W{1'b0}}}; // [RULE2]

    always @* begin
        next_rdata = 32'h00000000;
        case (dword_index)
            ID_OFS[7:2]: begin
                next_rdata = id_dword; // [RULE3]
            end
            CMD_OFS[7:2]: begin
                next_rdata = cmd_dword;
            end
            BASE_OFS[7:2]: begin
                next_rdata = base_dword;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // answer comes exactly one clock after any request, claimed or not
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_ack_out <= 1'b0;
        end else begin
            cfg_ack_out <= cfg_valid_in; // [RULE1]
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_claim_out <= 1'b0;
        end else begin
            cfg_claim_out <= cfg_valid_in & own_function; // [RULE1]
        end
    end

    // read data stands only with the answer; zero otherwise keeps the mux quiet
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_rdata_out <= 32'h00000000;
        end else if (cfg_read_hit) begin
            cfg_rdata_out <= next_rdata; // [RULE1]
        end else begin
            cfg_rdata_out <= 32'h00000000;
        end
    end

    // enables reset to zero, so no memory access is claimed and nothing mastered until software sets them
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            command_control <= `CMD_RESET; // [RULE7] [RULE8]
        end else begin
            command_control <= next_command; // [RULE7] [RULE8]
        end
    end

    // base resets to zero; software must program it before setting memory enable
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mmio_base <= `MMIO_BASE_RESET;
        end else begin
            mmio_base <= next_base; // [RULE2]
        end
    end

    mmio_window_decode #(
        .ADDR_WIDTH  (32),
        .WINDOW_BITS (WIN_W)
    ) u_decode (
        .access_valid_in   (mem_valid_in),
        .access_addr_in    (mem_addr_in),
        .window_base_in    (mmio_base),
        .decode_enable_in  (mem_enable),
        .window_hit_out    (window_hit),
        .window_offset_out (window_offset)
    );

    // hit registered so a settling address never glitches the claim
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_hit_out <= 1'b0;
        end else begin
            mem_hit_out <= window_hit; // [RULE2] [RULE7]
        end
    end

    // offset is zeroed on a miss so the memory side never sees a foreign address
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_offset_out <= {WIN_W{1'b0}};
        end else begin
            mem_offset_out <= window_hit ? window_offset : {WIN_W{1'b0}}; // [RULE2]
        end
    end

    // request drops within a cycle of clearing the enable
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            master_req_out <= 1'b0;
        end else begin
            master_req_out <= master_req_in & master_enable; // [RULE8]
        end
    end

    // registered copies keep every top output straight from a flop
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_enable_out <= 1'b0;
        end else begin
            mem_enable_out <= mem_enable; // [RULE7]
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            master_enable_out <= 1'b0;
        end else begin
            master_enable_out <= master_enable; // [RULE8]
        end
    end
endmodule

// ---- verification/cmd_header_props.sv ----
`timescale 1ns/10ps
module cmd_header_props #(parameter [15:0] DEVICE_CODE = 16'h5678) (
    input wire        clk_in,
    input wire        reset_n_in,
    input wire        cfg_valid_in,
    input wire        cfg_write_in,
    input wire [2:0]  cfg_function_in,
    input wire [7:0]  cfg_offset_in,
    input wire        cfg_ack_out,
    input wire        cfg_claim_out,
    input wire [31:0] cfg_rdata_out,
    input wire [31:0] mem_addr_in,
    input wire        mem_hit_out,
    input wire [10:0] mem_offset_out,
    input wire        master_req_in,
    input wire        master_req_out,
    input wire        mem_enable_out,
    input wire        master_enable_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_rd(o);
        cfg_valid_in && !cfg_write_in && cfg_function_in == 3'h0 && cfg_offset_in[7:2] == o;
    endsequence
    // three cycles so enable-copy lag cannot mask a late gate
    sequence s_mem_off; !mem_enable_out [*3]; endsequence
    sequence s_mst_off; !master_enable_out [*3]; endsequence
    property p_ack; cfg_valid_in |=> cfg_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_claim; cfg_valid_in && cfg_function_in != 3'h0 |=> !cfg_claim_out; endproperty
    a_claim: assert property (p_claim) else $error("foreign function claimed");
    property p_id; s_rd(6'h00) |=> cfg_rdata_out[31:16] == DEVICE_CODE; endproperty
    a_id: assert property (p_id) else $error("bad identifier");
    property p_cmd; s_rd(6'h01) |=> cfg_rdata_out[15:3] == 13'h0 && !cfg_rdata_out[0]; endproperty
    a_cmd: assert property (p_cmd) else $error("fixed bit set");
    property p_mem_off; s_mem_off |-> !mem_hit_out; endproperty
    a_mem_off: assert property (p_mem_off) else $error("hit while disabled");
    property p_off; mem_hit_out |-> {21'h0, mem_offset_out} == ($past(mem_addr_in) & 32'h7ff);
    endproperty
    a_off: assert property (p_off) else $error("bad offset");
    property p_mst_off; s_mst_off |-> !master_req_out; endproperty
    a_mst_off: assert property (p_mst_off) else $error("master while off");
    property p_mst; master_req_out |-> $past(master_req_in); endproperty
    a_mst: assert property (p_mst) else $error("master without request");
endmodule
bind pci_config_command_header cmd_header_props #(.DEVICE_CODE(DEVICE_CODE)) u_props (
    .clk_in            (clk_in),
    .reset_n_in        (reset_n_in),
    .cfg_valid_in      (cfg_valid_in),
    .cfg_write_in      (cfg_write_in),
    .cfg_function_in   (cfg_function_in),
    .cfg_offset_in     (cfg_offset_in),
    .cfg_ack_out       (cfg_ack_out),
    .cfg_claim_out     (cfg_claim_out),
    .cfg_rdata_out     (cfg_rdata_out),
    .mem_addr_in       (mem_addr_in),
    .mem_hit_out       (mem_hit_out),
    .mem_offset_out    (mem_offset_out),
    .master_req_in     (master_req_in),
    .master_req_out    (master_req_out),
    .mem_enable_out    (mem_enable_out),
    .master_enable_out (master_enable_out)
);

// ---- verification/pci_host_model.sv ----
`timescale 1ns/10ps
module pci_host_model (
    input  wire        clk_in,
    input  wire        go_in,
    input  wire [31:0] addr_in,
    output reg         mem_valid_out,
    output reg  [31:0] mem_addr_out
);
    initial begin mem_valid_out = 1'b0; mem_addr_out = 32'h0; end
    always @(posedge clk_in) begin
        mem_valid_out <= go_in;
        // idle address flips so a stale value never decodes by luck
        mem_addr_out <= go_in ? addr_in : ~mem_addr_out;
    end
endmodule

// ---- verification/pci_config_command_header_tb.sv ----
`timescale 1ns/10ps
module pci_config_command_header_tb;
    reg clk_in = 0, reset_n_in = 0, cfg_valid_in = 0, cfg_write_in = 0, go = 0, master_req_in = 0;
    reg [2:0] cfg_function_in = 0; reg [7:0] cfg_offset_in = 0; reg [3:0] cfg_byte_en_in = 0;
    reg [31:0] cfg_wdata_in = 0, addr = 0, seed = 32'h5980d71a, base;
    wire cfg_ack_out, cfg_claim_out, mem_valid_in, mem_hit_out, master_req_out;
    wire mem_enable_out, master_enable_out; wire [31:0] cfg_rdata_out, mem_addr_in;
    wire [10:0] mem_offset_out; reg [32:0] q[$]; integer fail_count = 0, samples_checked = 0, cyc = 0;
    always #5 clk_in = ~clk_in;
    localparam [15:0] VEN = 16'h2b1d, DEV = 16'h7c3e; // values are arbitrary
    pci_config_command_header #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) DUT (.clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cfg_valid_in(cfg_valid_in), .cfg_write_in(cfg_write_in), .cfg_function_in(cfg_function_in),
        .cfg_offset_in(cfg_offset_in), .cfg_byte_en_in(cfg_byte_en_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_ack_out(cfg_ack_out), .cfg_claim_out(cfg_claim_out), .cfg_rdata_out(cfg_rdata_out),
        .mem_valid_in(mem_valid_in), .mem_addr_in(mem_addr_in), .mem_hit_out(mem_hit_out),
        .mem_offset_out(mem_offset_out), .master_req_in(master_req_in),
        .master_req_out(master_req_out), .mem_enable_out(mem_enable_out),
        .master_enable_out(master_enable_out));
    pci_host_model host (.clk_in(clk_in), .go_in(go), .addr_in(addr),
        .mem_valid_out(mem_valid_in), .mem_addr_out(mem_addr_in));
    function [31:0] lfsr(input [31:0] s); lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
    task check(input [32:0] seen, input [32:0] exp, input string what);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cfg(input w, input [2:0] f, input [7:0] o, input [31:0] d, input [32:0] e);
        @(posedge clk_in);
        cfg_valid_in <= 1; cfg_write_in <= w; cfg_function_in <= f; cfg_offset_in <= o;
        cfg_byte_en_in <= 4'hf; cfg_wdata_in <= d; q.push_back(e);
        @(posedge clk_in);
        cfg_valid_in <= 0;
    endtask
    task mem(input [31:0] a, input h);
        @(posedge clk_in); go <= 1; addr <= a;
        @(posedge clk_in); go <= 0;
        @(posedge clk_in); #1 check({32'h0, mem_hit_out}, {32'h0, h}, "hit");
        check({22'h0, mem_offset_out}, {22'h0, h ? a[10:0] : 11'h000}, "offset");
    endtask
    task mst(input e);
        reg r;
        repeat (8) begin
            @(negedge clk_in); r = master_req_in;
            @(posedge clk_in);
            #1 check({32'h0, master_req_out}, {32'h0, e & r}, "master");
        end
    endtask
    always @(posedge clk_in) begin
        seed <= lfsr(seed); master_req_in <= seed[3]; cyc = cyc + 1;
        if (cfg_ack_out === 1'b1) begin
            check({cfg_claim_out, cfg_rdata_out}, q.pop_front(), "cfg");
        end
        if (cyc == 3000) begin fail_count = fail_count + 1; finish_test; end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1;
        cfg(0, 0, 8'h04, 0, {1'b1, 32'h0});
        cfg(0, 0, 8'h00, 0, {1'b1, DEV, VEN});
        cfg(1, 0, 8'h00, seed, {1'b1, 32'h0});
        cfg(0, 0, 8'h00, 0, {1'b1, DEV, VEN});
        cfg(1, 0, 8'h04, seed | 32'hfffe, {1'b1, 32'h0});
        cfg(0, 0, 8'h04, 0, {1'b1, 32'h6});
        cfg(1, 1, 8'h04, 0, {1'b0, 32'h0});
        cfg(0, 1, 8'h00, 0, {1'b0, 32'h0});
        cfg(0, 0, 8'h04, 0, {1'b1, 32'h6});
        #1 check({31'h0, mem_enable_out, master_enable_out}, 33'h3, "enables");
        mst(1);
        base = seed & 32'hfffff800;
        cfg(1, 0, 8'h10, base, {1'b1, 32'h0});
        cfg(0, 0, 8'h10, 0, {1'b1, base});
        mem(base | (seed & 32'h7ff), 1);
        mem(base ^ 32'h800, 0);
        cfg(1, 0, 8'h04, 0, {1'b1, 32'h0});
        mem(base | 32'h123, 0);
        mst(0);
        check({31'h0, mem_enable_out, master_enable_out}, 33'h0, "enables");
        repeat (3) @(posedge clk_in);
        finish_test;
    end
endmodule
